// *** include/chan_ctl_pkg.sv ***
// constants, field layouts and pin carriers of the channel control block
// assumes a 40 MHz system clock and a classic wishbone register master
// What this block does
// RQ1 - low direct-set input sets channel sync
// RQ2 - peripheral clock plus qualifier sets channel sync
// RQ3 - next request-enable strobe sets channel request
// RQ4 - request line driven only while gating asserted
// RQ5 - sync state true and complement, request status
// RQ6 - peripheral selects direction, high means input
// RQ7 - bus controller answers with out or in grant
// RQ8 - either load strobe loads address counter
// RQ9 - increment pulse advances address counter by one
// RQ10 - either enable drives address onto bus
// RQ11 - address counter overflow output for peripheral
// RQ12 - either load strobe loads word counter
// RQ13 - word clock counts up, value and carry out
// RQ14 - word count routable into input data path
// RQ15 - decode device code into primary, secondary selects
// RQ16 - interrupt ack returns code only if highest
// RQ17 - integrator straps code lsb for odd code
// RQ18 - start command or busy-set input sets busy
// RQ19 - busy state to bus and to peripheral
// RQ20 - done set by direct, clock with busy/enable
// RQ21 - done state to bus and to peripheral
// RQ22 - done then request-enable strobe raises interrupt
// RQ23 - busy-set input also clears done
// RQ24 - i/o reset clears sync, request, busy, done, interrupt
package chan_ctl_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SYNC_STAGES = 2;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_ADDR = 4'h8;
   localparam logic [3:0] OFS_WCNT = 4'hc;
   // control register fields
   localparam int CTRL_PRI_LO = 0;
   localparam int CTRL_SEC_LO = 6;
   localparam int CTRL_STRAP_BIT = 12;
   localparam int CTRL_ROUTE_BIT = 13;
   localparam int CTRL_W = 14;
   localparam logic [13:0] CTRL_RESET = 14'h0000;
   // status register fields
   localparam int ST_SYNC = 0;
   localparam int ST_REQ = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_DONE = 3;
   localparam int ST_INT = 4;
   localparam int ST_OVF = 5;
   localparam int ST_CARRY = 6;
   localparam int ST_DIR = 7;
   // status bits as driven onto the i/o bus
   localparam int BUS_BUSY_BIT = 0;
   localparam int BUS_DONE_BIT = 1;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] BUS_RESET = 16'h0000;

   typedef struct packed {
      logic sync_set_n;
      logic sync_clk;
      logic sync_qual_a;
      logic sync_qual_b;
      logic request_enable_strobe;
      logic req_gate;
      logic direction_select;
      logic channel_out_grant_n;
      logic channel_in_grant_n;
      logic addr_load_a;
      logic addr_load_b;
      logic addr_inc;
      logic addr_oe_a;
      logic addr_oe_b;
      logic wcnt_load_a;
      logic wcnt_load_b;
      logic wcnt_clk;
      logic start_cmd;
      logic clear_cmd;
      logic io_reset;
      logic interrupt_ack_command;
      logic priority_in;
      logic busy_set;
      logic status_en;
      logic done_set_n;
      logic done_clk;
      logic done_enable;
      logic in_data_en;
      logic [5:0] dev_code;
      logic [15:0] out_data;
      logic [15:0] in_data;
   } pin_in_t;

   typedef struct packed {
      logic channel_request_line;
      logic sync_q;
      logic sync_qn;
      logic request_status;
      logic channel_out_grant;
      logic channel_in_grant;
      logic direction;
      logic busy;
      logic done;
      logic int_req;
      logic primary_select;
      logic secondary_select;
      logic addr_overflow;
      logic wcnt_carry;
      logic [15:0] word_count;
   } pin_out_t;

   localparam pin_out_t PIN_OUT_RESET = '{sync_qn: 1'b1, default: '0};
   // resting pin levels; the active-low ones sit high
   localparam pin_in_t PIN_IN_IDLE = '{sync_set_n: 1'b1, done_set_n: 1'b1,
      channel_out_grant_n: 1'b1, channel_in_grant_n: 1'b1, default: '0};
endpackage

// *** rtl/chan_ctl.sv ***
// data channel, busy/done and interrupt request control
// assumes peripheral and bus pins are asynchronous to clk_sys and held
// for at least three clocks; registers sit on a classic wishbone slave
module chan_ctl
   import chan_ctl_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire pin_in_t pin_i,
   output pin_out_t pin_o,
   output logic [15:0] bus_data_o,
   output logic bus_data_oe,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   localparam int PIN_W = $bits(pin_in_t);
   localparam logic [PIN_W-1:0] IDLE_V = PIN_IN_IDLE;

   // two-flop synchronisers, third stage only for edge detection
   // reset to idle levels, else a false set or edge follows reset
   logic [PIN_W-1:0] s1_r, s2_r, s3_r;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[gi] <= IDLE_V[gi];
               s2_r[gi] <= IDLE_V[gi];
               s3_r[gi] <= IDLE_V[gi];
            end else begin
               s1_r[gi] <= pin_i[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
            end
         end
      end
   endgenerate

   pin_in_t ps, pp;
   assign ps = pin_in_t'(s2_r);
   assign pp = pin_in_t'(s3_r);

   // rising edges stand for the peripheral's clock pulses
   logic sync_clk_ev, request_enable_strobe_ev, addr_inc_ev, wcnt_clk_ev, start_ev;
   logic clear_ev, busy_set_ev, done_clk_ev, grant_ev, iack_ev;
   assign sync_clk_ev = ps.sync_clk & ~pp.sync_clk;
   assign request_enable_strobe_ev = ps.request_enable_strobe & ~pp.request_enable_strobe;
   assign addr_inc_ev = ps.addr_inc & ~pp.addr_inc;
   assign wcnt_clk_ev = ps.wcnt_clk & ~pp.wcnt_clk;
   assign start_ev = ps.start_cmd & ~pp.start_cmd;
   assign clear_ev = ps.clear_cmd & ~pp.clear_cmd;
   assign busy_set_ev = ps.busy_set & ~pp.busy_set;
   assign done_clk_ev = ps.done_clk & ~pp.done_clk;
   assign iack_ev = ps.interrupt_ack_command & ~pp.interrupt_ack_command;
   // grants are active low on the bus
   assign grant_ev = (~ps.channel_out_grant_n & pp.channel_out_grant_n)
                   | (~ps.channel_in_grant_n & pp.channel_in_grant_n);

   // registers
   logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [5:0] pri_code, sec_code;
   assign pri_code = ctrl_r[CTRL_PRI_LO +: 6];
   assign sec_code = ctrl_r[CTRL_SEC_LO +: 6];

   logic pri_sel, sec_sel;
   assign pri_sel = (ps.dev_code == pri_code); // [RQ15]
   assign sec_sel = (ps.dev_code == sec_code); // [RQ15]

   // flag state
   logic sync_r, sync_nxt, req_r, req_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, int_r, int_nxt;
   logic done_set;

   always_comb begin
      sync_nxt = sync_r;
      req_nxt = req_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      int_nxt = int_r;
      done_set = ~ps.done_set_n // [RQ20]
               | (done_clk_ev & (busy_r | ps.done_enable)); // [RQ20]
      // a grant ends the request; a fresh set in the same cycle wins
      if (grant_ev) begin
         sync_nxt = 1'b0;
         req_nxt = 1'b0;
      end
      if (request_enable_strobe_ev && sync_r) begin
         req_nxt = 1'b1; // [RQ3]
      end
      if (~ps.sync_set_n) begin
         sync_nxt = 1'b1; // [RQ1]
      end
      if (sync_clk_ev && (ps.sync_qual_a || ps.sync_qual_b)) begin
         sync_nxt = 1'b1; // [RQ2]
      end
      if (clear_ev && pri_sel) begin
         busy_nxt = 1'b0;
         done_nxt = 1'b0;
      end
      if (busy_set_ev) begin
         done_nxt = 1'b0; // [RQ23]
      end
      if ((start_ev && pri_sel) || busy_set_ev) begin
         busy_nxt = 1'b1; // [RQ18]
      end
      if (done_set) begin
         done_nxt = 1'b1; // [RQ20]
      end
      // interrupt follows done; it drops once done is cleared
      if (!done_r) begin
         int_nxt = 1'b0;
      end
      if (request_enable_strobe_ev && done_r) begin
         int_nxt = 1'b1; // [RQ22]
      end
      if (ps.io_reset) begin
         sync_nxt = 1'b0; // [RQ24]
         req_nxt = 1'b0;
         busy_nxt = 1'b0;
         done_nxt = 1'b0;
         int_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_r <= 1'b0;
         req_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         int_r <= 1'b0;
      end else begin
         sync_r <= sync_nxt;
         req_r <= req_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         int_r <= int_nxt;
      end
   end

   // address and word counters; a load beats a count in the same cycle
   logic [CNT_W-1:0] addr_r, addr_nxt, wcnt_r, wcnt_nxt;
   logic ovf_r, ovf_nxt;

   always_comb begin
      addr_nxt = addr_r;
      wcnt_nxt = wcnt_r;
      ovf_nxt = ovf_r;
      if (ps.addr_load_a || ps.addr_load_b) begin
         addr_nxt = ps.out_data[CNT_W-1:0]; // [RQ8]
         ovf_nxt = 1'b0;
      end else if (addr_inc_ev) begin
         addr_nxt = addr_r + 1'b1; // [RQ9]
         if (&addr_r) begin
            ovf_nxt = 1'b1; // [RQ11]
         end
      end
      if (ps.wcnt_load_a || ps.wcnt_load_b) begin
         wcnt_nxt = ps.out_data[CNT_W-1:0]; // [RQ12]
      end else if (wcnt_clk_ev) begin
         wcnt_nxt = wcnt_r + 1'b1; // [RQ13]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= CNT_RESET[CNT_W-1:0];
         wcnt_r <= CNT_RESET[CNT_W-1:0];
         ovf_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         wcnt_r <= wcnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // i/o bus drive, one source at a time in fixed priority
   logic [15:0] bus_nxt;
   logic bus_oe_nxt;
   logic [5:0] ret_code;

   always_comb begin
      bus_nxt = BUS_RESET;
      bus_oe_nxt = 1'b0;
      ret_code = pri_code;
      ret_code[0] = pri_code[0] | ctrl_r[CTRL_STRAP_BIT]; // [RQ17]
      if (ps.interrupt_ack_command) begin
         // only the highest requester answers the acknowledge
         if (int_r && ps.priority_in) begin
            bus_nxt = {10'h000, ret_code}; // [RQ16]
            bus_oe_nxt = 1'b1;
         end
      end else if (ps.addr_oe_a || ps.addr_oe_b) begin
         bus_nxt = 16'(addr_r); // [RQ10]
         bus_oe_nxt = 1'b1;
      end else if (ps.in_data_en) begin
         bus_nxt = ctrl_r[CTRL_ROUTE_BIT] ? 16'(wcnt_r) // [RQ14]
                                          : ps.in_data;
         bus_oe_nxt = 1'b1;
      end else if (pri_sel || ps.status_en) begin
         bus_nxt[BUS_BUSY_BIT] = busy_r; // [RQ19]
         bus_nxt[BUS_DONE_BIT] = done_r; // [RQ21]
         bus_oe_nxt = 1'b1;
      end
   end

   // peripheral-side outputs, all registered
   pin_out_t po_nxt;
   always_comb begin
      po_nxt = PIN_OUT_RESET;
      po_nxt.channel_request_line = req_r & ps.req_gate; // [RQ4]
      po_nxt.sync_q = sync_r; // [RQ5]
      po_nxt.sync_qn = ~sync_r; // [RQ5]
      po_nxt.request_status = req_r; // [RQ5]
      po_nxt.channel_out_grant = ~ps.channel_out_grant_n; // [RQ7]
      po_nxt.channel_in_grant = ~ps.channel_in_grant_n; // [RQ7]
      po_nxt.direction = ps.direction_select; // [RQ6]
      po_nxt.busy = busy_r; // [RQ19]
      po_nxt.done = done_r; // [RQ21]
      po_nxt.int_req = int_r; // [RQ22]
      po_nxt.primary_select = pri_sel; // [RQ15]
      po_nxt.secondary_select = sec_sel; // [RQ15]
      po_nxt.addr_overflow = ovf_r; // [RQ11]
      po_nxt.wcnt_carry = &wcnt_r; // [RQ13]
      po_nxt.word_count = 16'(wcnt_r); // [RQ13]
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_o <= PIN_OUT_RESET;
         bus_data_o <= BUS_RESET;
         bus_data_oe <= 1'b0;
      end else begin
         pin_o <= po_nxt;
         bus_data_o <= bus_nxt;
         bus_data_oe <= bus_oe_nxt;
      end
   end

   // wishbone slave: ack one cycle after the strobe, dropped after one
   logic ack_nxt;
   logic [31:0] dat_nxt;
   logic [7:0] status_v;
   logic wb_hit;
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_comb begin
      status_v = '0;
      status_v[ST_SYNC] = sync_r;
      status_v[ST_REQ] = req_r;
      status_v[ST_BUSY] = busy_r;
      status_v[ST_DONE] = done_r;
      status_v[ST_INT] = int_r;
      status_v[ST_OVF] = ovf_r;
      status_v[ST_CARRY] = &wcnt_r;
      status_v[ST_DIR] = ps.direction_select;
      ack_nxt = wb_hit;
      dat_nxt = '0;
      ctrl_nxt = ctrl_r;
      if (wb_hit && wb_we_i && wb_adr_i == OFS_CTRL) begin
         if (wb_sel_i[0]) begin
            ctrl_nxt[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_nxt[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
         end
      end
      if (wb_hit && !wb_we_i) begin
         unique case (wb_adr_i)
            OFS_CTRL: dat_nxt = 32'(ctrl_r);
            OFS_STATUS: dat_nxt = 32'(status_v);
            OFS_ADDR: dat_nxt = 32'(addr_r);
            OFS_WCNT: dat_nxt = 32'(wcnt_r);
            default: dat_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_sync_direct_set: assert property ( // [RQ1]
      !ps.sync_set_n && !ps.io_reset |=> sync_r)
      else $error("direct set did not set channel sync");
   a_sync_clock_set: assert property ( // [RQ2]
      sync_clk_ev && (ps.sync_qual_a || ps.sync_qual_b) && !ps.io_reset
      |=> sync_r ##1 pin_o.sync_q)
      else $error("qualified clock did not set channel sync");
   a_req_on_strobe: assert property ( // [RQ3]
      request_enable_strobe_ev && sync_r && !ps.io_reset |=> req_r)
      else $error("request not set on request-enable strobe");
   a_req_line_gated: assert property ( // [RQ4]
      pin_o.channel_request_line |-> $past(req_r) && $past(ps.req_gate))
      else $error("request line driven without gating");
   a_sync_pair_out: assert property ( // [RQ5]
      pin_o.sync_q != pin_o.sync_qn)
      else $error("sync outputs not complementary");
   a_addr_count_up: assert property ( // [RQ9]
      addr_inc_ev && !ps.addr_load_a && !ps.addr_load_b
      |=> addr_r == $past(addr_r) + 1'b1)
      else $error("address counter did not advance by one");
   a_addr_load_val: assert property ( // [RQ8]
      ps.addr_load_a |=> addr_r == $past(ps.out_data))
      else $error("address counter load lost");
   a_wcnt_count_up: assert property ( // [RQ13]
      wcnt_clk_ev && !ps.wcnt_load_a && !ps.wcnt_load_b
      |=> wcnt_r == $past(wcnt_r) + 1'b1 ##1 pin_o.word_count == $past(wcnt_r))
      else $error("word counter did not advance by one");
   a_busy_set_clr: assert property ( // [RQ23]
      busy_set_ev && !done_set && !ps.io_reset |=> busy_r && !done_r)
      else $error("busy-set did not set busy and clear done");
   a_done_on_clock: assert property ( // [RQ20]
      done_clk_ev && busy_r && !ps.io_reset |=> done_r)
      else $error("done clock with busy did not set done");
   a_int_after_done: assert property ( // [RQ22]
      request_enable_strobe_ev && done_r && !ps.io_reset |=> int_r ##1 pin_o.int_req)
      else $error("interrupt not raised on strobe after done");
   a_io_reset_clr: assert property ( // [RQ24]
      ps.io_reset |=> !sync_r && !req_r && !busy_r && !done_r && !int_r)
      else $error("i/o reset left a flag set");
   a_iack_code: assert property ( // [RQ16]
      bus_data_oe && $past(ps.interrupt_ack_command)
      |-> $past(int_r) && $past(ps.priority_in))
      else $error("code returned while not highest requester");
   a_addr_overflow: assert property ( // [RQ11]
      addr_inc_ev && &addr_r && !ps.addr_load_a && !ps.addr_load_b
      |=> ovf_r)
      else $error("address counter wrap did not flag overflow");
   a_addr_on_bus: assert property ( // [RQ10]
      (ps.addr_oe_a || ps.addr_oe_b) && !ps.interrupt_ack_command
      |=> bus_data_oe && bus_data_o == 16'($past(addr_r)))
      else $error("address counter not driven onto bus");
   a_wcnt_load_val: assert property ( // [RQ12]
      ps.wcnt_load_a || ps.wcnt_load_b
      |=> wcnt_r == $past(ps.out_data[CNT_W-1:0]))
      else $error("word counter load lost");
   a_wcnt_routed: assert property ( // [RQ14]
      ps.in_data_en && ctrl_r[CTRL_ROUTE_BIT] && !ps.interrupt_ack_command
      && !ps.addr_oe_a && !ps.addr_oe_b
      |=> bus_data_o == 16'($past(wcnt_r)))
      else $error("word count not routed to input data");
   a_busy_on_start: assert property ( // [RQ18]
      start_ev && pri_sel && !ps.io_reset |=> busy_r)
      else $error("start command did not set busy");
   a_done_direct_set: assert property ( // [RQ20]
      !ps.done_set_n && !ps.io_reset |=> done_r)
      else $error("direct set did not set done");
   a_status_on_bus: assert property ( // [RQ19] [RQ21]
      ps.status_en && !ps.interrupt_ack_command && !ps.addr_oe_a
      && !ps.addr_oe_b && !ps.in_data_en
      |=> bus_data_oe && bus_data_o[BUS_BUSY_BIT] == $past(busy_r)
      && bus_data_o[BUS_DONE_BIT] == $past(done_r))
      else $error("busy and done not placed on bus");
endmodule

// *** testbench/bus_ctl_model.sv ***
// bus controller stand-in: grants each channel request after a delay
// assumes request line and direction come straight from the block pins
module bus_ctl_model
   import chan_ctl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_line,
   input wire logic dir,
   input wire logic [7:0] dly,
   output logic out_grant_n,
   output logic in_grant_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r;
   logic act;

   // grant held 8 clocks, long enough for the pin synchroniser
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (cnt_r != 8'h00 || req_line) begin
         cnt_r <= (cnt_r == dly + 8'h08) ? 8'h00 : cnt_r + 8'h01;
      end
   end
   assign act = (cnt_r > dly) && (cnt_r <= dly + 8'h08);
   // idle lines sit high, grant picks side by direction
   assign out_grant_n = !(act && !dir);
   assign in_grant_n = !(act && dir);
endmodule

// *** testbench/io_bus_channel_interrupt_control_test.sv ***
// self-checking bench of the channel control block
// assumes a bus controller model and bench-driven peripheral pins
module io_bus_channel_interrupt_control_test
   import chan_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, bd_oe, cyc, stb, we, ack, go_n, gi_n;
   pin_in_t p, pin, m;
   pin_out_t po;
   logic [15:0] bd;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, d;
   logic [7:0] dly;
   int n_errors = 0;
   int n_compared = 0;
   int cyc_cnt = 0;

   chan_ctl #(.CNT_W(16)) u_chan_ctl (.clk_sys(clk_sys), .rst_n(rst_n),
      .pin_i(pin), .pin_o(po), .bus_data_o(bd), .bus_data_oe(bd_oe),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   bus_ctl_model u_bus_ctl_model (.clk_sys(clk_sys), .rst_n(rst_n),
      .req_line(po.channel_request_line), .dir(pin.direction_select),
      .dly(dly), .out_grant_n(go_n), .in_grant_n(gi_n));

   always_comb begin
      pin = p;
      pin.channel_out_grant_n = go_n;
      pin.channel_in_grant_n = gi_n;
   end

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %0h", $time, msg, got);
      end
   endtask

   // one classic cycle; read data lands in d
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] v);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= v;
      @(posedge clk_sys);
      while (ack !== 1'b1) @(posedge clk_sys);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // pins are synchronised: hold 4 clocks, then let 6 settle; the
   // leading edge lets the caller's field writes land before p is read
   task automatic pulse(input pin_in_t mk, input logic lo);
      @(posedge clk_sys);
      p <= lo ? pin_in_t'(p & ~mk) : pin_in_t'(p | mk);
      wt(4);
      p <= lo ? pin_in_t'(p | mk) : pin_in_t'(p & ~mk);
      wt(6);
   endtask

   task automatic wait_grant(input logic in_side);
      int k;
      k = 0;
      while (k < 60 && (in_side ? po.channel_in_grant
                                : po.channel_out_grant) !== 1'b1) begin
         wt(1);
         k++;
      end
   endtask

   task automatic t_reset();
      cmp(po, PIN_OUT_RESET, "pin reset");
      cmp(bd_oe, 0, "bus idle");
      wb(1, OFS_STATUS, 32'hffff_ffff);
      wb(0, OFS_STATUS, 0);
      cmp(d, 0, "status ro");
      $display("test reset done");
   endtask

   task automatic t_sync();
      dly <= 8'd20;
      p.direction_select <= 1'b1;
      m = '0;
      m.sync_set_n = 1'b1;
      pulse(m, 1'b1);
      cmp(po.sync_q, 1, "sync direct");
      cmp(po.sync_qn, 0, "sync inverse");
      cmp(po.request_status, 0, "request early");
      m = '0;
      m.request_enable_strobe = 1'b1;
      pulse(m, 1'b0);
      cmp(po.request_status, 1, "request set");
      cmp(po.channel_request_line, 0, "line ungated");
      p.req_gate <= 1'b1;
      wt(6);
      cmp(po.channel_request_line, 1, "line gated");
      cmp(po.direction, 1, "direction in");
      wait_grant(1'b1);
      cmp(po.channel_in_grant, 1, "in grant");
      wt(20);
      cmp(po.sync_q, 0, "sync cleared");
      dly <= 8'd0;
      p.direction_select <= 1'b0;
      m = '0;
      m.sync_clk = 1'b1;
      pulse(m, 1'b0);
      cmp(po.sync_q, 0, "sync unqualified");
      for (int i = 0; i < 2; i++) begin
         p.sync_qual_a <= (i == 0);
         p.sync_qual_b <= (i == 1);
         pulse(m, 1'b0);
         cmp(po.sync_q, 1, "sync qualified");
         m.sync_clk = 1'b0;
         m.request_enable_strobe = 1'b1;
         pulse(m, 1'b0);
         wait_grant(1'b0);
         cmp(po.channel_out_grant, 1, "out grant");
         wt(20);
         cmp(po.sync_q, 0, "sync cleared");
         m = '0;
         m.sync_clk = 1'b1;
      end
      p.sync_qual_a <= 1'b0;
      p.sync_qual_b <= 1'b0;
      p.req_gate <= 1'b0;
      $display("test channel request done");
   endtask

   task automatic t_addr();
      p.out_data <= 16'h1233;
      m = '0;
      m.addr_load_a = 1'b1;
      pulse(m, 1'b0);
      m = '0;
      m.addr_inc = 1'b1;
      repeat (3) pulse(m, 1'b0);
      wb(0, OFS_ADDR, 0);
      cmp(d, 32'h1236, "address count");
      cmp(po.addr_overflow, 0, "no overflow");
      for (int i = 0; i < 2; i++) begin
         m = '0;
         if (i == 0) m.addr_oe_a = 1'b1;
         else m.addr_oe_b = 1'b1;
         p <= pin_in_t'(p | m);
         wt(6);
         cmp({bd_oe, bd}, 32'h1_1236, "address on bus");
         p <= pin_in_t'(p & ~m);
         wt(6);
      end
      p.out_data <= 16'hffff;
      m = '0;
      m.addr_load_b = 1'b1;
      pulse(m, 1'b0);
      m = '0;
      m.addr_inc = 1'b1;
      pulse(m, 1'b0);
      cmp(po.addr_overflow, 1, "overflow");
      $display("test address done");
   endtask

   task automatic t_wcnt();
      p.out_data <= 16'h00fd;
      m = '0;
      m.wcnt_load_b = 1'b1;
      pulse(m, 1'b0);
      cmp(po.word_count, 16'h00fd, "count load");
      m = '0;
      m.wcnt_clk = 1'b1;
      pulse(m, 1'b0);
      cmp({po.wcnt_carry, po.word_count}, 32'h00fe, "count up");
      p.out_data <= 16'hfffe;
      m.wcnt_clk = 1'b0;
      m.wcnt_load_a = 1'b1;
      pulse(m, 1'b0);
      m = '0;
      m.wcnt_clk = 1'b1;
      pulse(m, 1'b0);
      cmp({po.wcnt_carry, po.word_count}, 32'h1_ffff, "carry");
      wb(0, OFS_WCNT, 0);
      cmp(d, 32'hffff, "count reg");
      wb(1, OFS_CTRL, 32'h2000);
      p.in_data <= 16'h5a5a;
      p.in_data_en <= 1'b1;
      wt(6);
      cmp(bd, 16'hffff, "count routed");
      wb(1, OFS_CTRL, 32'h0);
      wt(6);
      cmp(bd, 16'h5a5a, "input data");
      p.in_data_en <= 1'b0;
      $display("test word count done");
   endtask

   task automatic t_flags();
      wb(1, OFS_CTRL, 32'h130a);
      wb(0, OFS_CTRL, 0);
      cmp(d, 32'h130a, "ctrl readback");
      p.dev_code <= 6'h0c;
      wt(6);
      cmp({po.primary_select, po.secondary_select}, 1, "sec sel");
      p.dev_code <= 6'h0a;
      wt(6);
      cmp({po.primary_select, po.secondary_select}, 2, "pri sel");
      m = '0;
      m.start_cmd = 1'b1;
      pulse(m, 1'b0);
      cmp(po.busy, 1, "busy start");
      cmp(bd[1:0], 2'b01, "busy on bus");
      m = '0;
      m.done_clk = 1'b1;
      pulse(m, 1'b0);
      cmp({po.done, po.int_req}, 2'b10, "done by busy");
      m = '0;
      m.request_enable_strobe = 1'b1;
      pulse(m, 1'b0);
      cmp(po.int_req, 1, "interrupt");
      wb(0, OFS_STATUS, 0);
      cmp(d[4:0], 5'b11100, "status flags");
      p.dev_code <= 6'h00;
      p.status_en <= 1'b1;
      wt(6);
      cmp({bd_oe, bd[1:0]}, 3'b111, "status enable");
      p.status_en <= 1'b0;
      p.interrupt_ack_command <= 1'b1;
      wt(6);
      cmp(bd_oe, 0, "no code, lower priority");
      p.priority_in <= 1'b1;
      wt(6);
      cmp({bd_oe, bd[5:0]}, 7'h4b, "code return");
      p.interrupt_ack_command <= 1'b0;
      p.priority_in <= 1'b0;
      m = '0;
      m.busy_set = 1'b1;
      pulse(m, 1'b0);
      cmp({po.busy, po.done}, 2'b10, "busy set clears done");
      m = '0;
      m.io_reset = 1'b1;
      pulse(m, 1'b0);
      cmp(po.busy, 0, "io reset busy");
      m = '0;
      m.done_set_n = 1'b1;
      m.sync_set_n = 1'b1;
      pulse(m, 1'b1);
      cmp({po.done, po.sync_q}, 2'b11, "direct sets");
      m = '0;
      m.io_reset = 1'b1;
      pulse(m, 1'b0);
      cmp({po.done, po.sync_q, po.int_req}, 0, "io reset");
      m = '0;
      m.done_clk = 1'b1;
      pulse(m, 1'b0);
      cmp(po.done, 0, "done unqualified");
      p.done_enable <= 1'b1;
      pulse(m, 1'b0);
      cmp(po.done, 1, "done by enable");
      p.done_enable <= 1'b0;
      p.dev_code <= 6'h0a;
      m = '0;
      m.clear_cmd = 1'b1;
      pulse(m, 1'b0);
      cmp(po.done, 0, "clear command");
      $display("test busy done done");
   endtask

   initial begin
      p = '0;
      p.sync_set_n = 1'b1;
      p.done_set_n = 1'b1;
      // matches no device code, so the bus stays idle
      p.dev_code = 6'h3f;
      {cyc, stb, we, adr, sel, wdat} = '0;
      dly = 8'd20;
      rst_n = 1'b0;
      wt(6);
      rst_n <= 1'b1;
      wt(8);
      t_reset();
      t_sync();
      t_addr();
      t_wcnt();
      t_flags();
      stop_test();
   end
endmodule
